/* pkt_seq_pkg.sv */
package pkt_seq_pkg;

  localparam int WORD_W    = 32;
  localparam int IDX_W     = 3;
  localparam int WNUM_W    = 3;
  localparam int PHASE_W   = 2;
  localparam int BLOCK_W   = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW   = 4;

  localparam logic [IDX_W-1:0] WORDS_PER_BLOCK = 3'h7;
  localparam logic [IDX_W-1:0] BIW_INDEX       = 3'h0;

  localparam logic [1:0] RATE_LOW  = 2'h0;
  localparam logic [1:0] RATE_MID  = 2'h1;
  localparam logic [1:0] RATE_HIGH = 2'h2;

  localparam logic [PHASE_W-1:0] PHASE_A = 2'h0;
  localparam logic [PHASE_W-1:0] PHASE_B = 2'h1;
  localparam logic [PHASE_W-1:0] PHASE_C = 2'h2;
  localparam logic [PHASE_W-1:0] PHASE_D = 2'h3;

  typedef enum logic [2:0] {
    WT_IDLE, WT_BIW, WT_ADDR, WT_LONG_ADDR, WT_VECTOR, WT_MESSAGE
  } word_type_t;

  typedef enum logic [1:0] {
    PK_ADDRESS, PK_VECTOR, PK_MESSAGE, PK_BIW
  } pkt_type_t;

  localparam int PKT_W = 2 + PHASE_W + BLOCK_W + 8 + 8 + WORD_W;

endpackage

/* pkt_fifo_if.sv */
interface pkt_fifo_if #(
  parameter int W = 8
);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;

  modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

/* pkt_fifo.sv */
module pkt_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic mclk_i,
  input  wire logic reset_i,
  pkt_fifo_if.fifo  q
);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          push, pop;

  assign q.in_ready  = (cnt_r < (AW+1)'(DEPTH));
  assign q.out_valid = (cnt_r != '0);
  assign q.out_data  = mem[rp_r];
  assign push        = q.in_valid && q.in_ready;
  assign pop         = q.out_valid && q.out_ready;

  always_comb begin
    wp_nxt  = push ? wp_r + 1'b1 : wp_r;
    rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wp_r] <= q.in_data;
    end
  end

endmodule

/* pkt_sequencer.sv */
module pkt_sequencer
  import pkt_seq_pkg::*;
(
  input  wire logic                           mclk_i,
  input  wire logic                           reset_i,
  input  wire logic [1:0]                     rate_i,
  input  wire logic                           biw_report_en_i,
  input  wire logic                           blk_valid_i,
  output logic                                blk_ready_o,
  input  wire logic [pkt_seq_pkg::BLOCK_W-1:0] blk_num_i,
  input  wire logic [pkt_seq_pkg::PHASE_W-1:0] word_phase_i,
  input  wire logic [pkt_seq_pkg::WNUM_W-1:0]  word_index_i,
  input  wire logic [2:0]                     word_type_i,
  input  wire logic [7:0]                     ref_index_i,
  input  wire logic [7:0]                     ref_len_i,
  input  wire logic [pkt_seq_pkg::WORD_W-1:0]  word_data_i,
  output logic                                pkt_valid_o,
  input  wire logic                           pkt_ready_i,
  output logic [1:0]                          pkt_type_o,
  output logic [pkt_seq_pkg::PHASE_W-1:0]     pkt_phase_o,
  output logic [pkt_seq_pkg::BLOCK_W-1:0]     pkt_block_o,
  output logic [7:0]                          pkt_ref_o,
  output logic [7:0]                          pkt_aux_o,
  output logic [pkt_seq_pkg::WORD_W-1:0]      pkt_data_o
);
  import pkt_seq_pkg::*;

  // ------------------------------------------------------------
  // Block store: one block of all phases, loaded then walked
  // ------------------------------------------------------------
  localparam int SLOTS = 32;
  localparam int SLOT_W = 5;

  typedef enum logic [1:0] {S_LOAD, S_WALK, S_DONE} state_t;

  logic [2:0]       typ_r  [SLOTS];
  logic [7:0]       ref_r  [SLOTS];
  logic [7:0]       len_r  [SLOTS];
  logic [WORD_W-1:0] dat_r [SLOTS];

  state_t               state_r, state_nxt;
  logic [BLOCK_W-1:0]   blk_r, blk_nxt;
  logic [SLOT_W-1:0]    pos_r, pos_nxt;
  logic [PHASE_W-1:0]   last_phase;
  logic                 load_wr;
  logic [SLOT_W-1:0]    load_slot;
  logic                 load_end;
  logic                 walk_end;
  logic [PHASE_W-1:0]   walk_last_r, walk_last_nxt;
  logic                 walk_biw_en_r, walk_biw_en_nxt;

  // ------------------------------------------------------------
  // Packet FIFO between walk and output register
  // ------------------------------------------------------------
  pkt_fifo_if #(.W(PKT_W)) fq ();

  pkt_fifo #(
    .W     (PKT_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .q       (fq)
  );

  // ------------------------------------------------------------
  // Phase count per rate
  // ------------------------------------------------------------
  // phase count
  always_comb begin
    case (rate_i)
      RATE_HIGH: last_phase = PHASE_D;
      RATE_MID:  last_phase = PHASE_B;
      RATE_LOW:  last_phase = PHASE_A;
      default:   last_phase = PHASE_A;
    endcase
  end

  // ------------------------------------------------------------
  // Load side
  // ------------------------------------------------------------
  assign blk_ready_o = (state_r == S_LOAD);
  assign load_wr     = blk_valid_i && blk_ready_o;
  assign load_slot   = {word_phase_i, word_index_i};
  // last word of last phase closes the block
  assign load_end    = load_wr && (word_phase_i == last_phase) &&
                       (word_index_i == WORDS_PER_BLOCK);

  // ------------------------------------------------------------
  // Slot store: loads one word, empties after each walk
  // ------------------------------------------------------------
  logic [2:0]        typ_nxt [SLOTS];
  logic [7:0]        ref_nxt [SLOTS];
  logic [7:0]        len_nxt [SLOTS];
  logic [WORD_W-1:0] dat_nxt [SLOTS];

  for (genvar s = 0; s < SLOTS; s++) begin : g_slot
    logic hit;

    assign hit = load_wr && (load_slot == SLOT_W'(s));

    always_comb begin
      typ_nxt[s] = typ_r[s];
      ref_nxt[s] = ref_r[s];
      len_nxt[s] = len_r[s];
      dat_nxt[s] = dat_r[s];
      if (hit) begin
        typ_nxt[s] = word_type_i;
        ref_nxt[s] = ref_index_i;
        len_nxt[s] = ref_len_i;
        dat_nxt[s] = word_data_i;
      end else if (state_r == S_DONE) begin
        typ_nxt[s] = WT_IDLE;
      end
    end

    // Only the type needs a reset: idle slots never emit
    always_ff @(posedge mclk_i) begin
      if (reset_i) begin
        typ_r[s] <= WT_IDLE;
      end else begin
        typ_r[s] <= typ_nxt[s];
      end
      ref_r[s] <= ref_nxt[s];
      len_r[s] <= len_nxt[s];
      dat_r[s] <= dat_nxt[s];
    end
  end

  // ------------------------------------------------------------
  // Walk: phases ascending, word index ascending
  // ------------------------------------------------------------
  logic [2:0]         cur_typ;
  logic [PHASE_W-1:0] cur_phase;
  logic [WNUM_W-1:0]  cur_idx;
  logic               emit;
  logic [1:0]         emit_type;
  logic [7:0]         emit_ref;
  logic [7:0]         emit_aux;
  logic               advance;

  assign cur_typ   = typ_r[pos_r];
  assign cur_phase = pos_r[SLOT_W-1:WNUM_W];
  assign cur_idx   = pos_r[WNUM_W-1:0];

  always_comb begin
    emit      = 1'b0;
    emit_type = PK_MESSAGE;
    emit_ref  = ref_r[pos_r];
    emit_aux  = len_r[pos_r];
    case (word_type_t'(cur_typ))
      WT_BIW: begin
        emit      = walk_biw_en_r;
        emit_type = PK_BIW;
      end
      WT_ADDR, WT_LONG_ADDR: begin
        emit      = 1'b1;
        emit_type = PK_ADDRESS;
      end
      WT_VECTOR: begin
        emit      = 1'b1;
        emit_type = PK_VECTOR;
      end
      WT_MESSAGE: begin
        emit      = 1'b1;
        emit_type = PK_MESSAGE;
      end
      default: emit = 1'b0;
    endcase
    if (cur_idx == BIW_INDEX) begin
      emit = 1'b0;
    end
  end

  assign advance  = (state_r == S_WALK) && (!emit || fq.in_ready);
  assign walk_end = (cur_phase == walk_last_r) && (cur_idx == WORDS_PER_BLOCK);

  assign fq.in_valid = (state_r == S_WALK) && emit;
  assign fq.in_data  = {emit_type, cur_phase, blk_r, emit_ref, emit_aux, dat_r[pos_r]};

  // ------------------------------------------------------------
  // Walk state
  // ------------------------------------------------------------
  always_comb begin
    state_nxt       = state_r;
    pos_nxt         = pos_r;
    blk_nxt         = blk_r;
    walk_last_nxt   = walk_last_r;
    walk_biw_en_nxt = walk_biw_en_r;
    case (state_r)
      S_LOAD: begin
        if (load_wr) begin
          blk_nxt = blk_num_i;
        end
        // rate held for the walk, a late change cannot cut it
        if (load_end) begin
          state_nxt       = S_WALK;
          pos_nxt         = '0;
          walk_last_nxt   = last_phase;
          walk_biw_en_nxt = biw_report_en_i;
        end
      end
      S_WALK: begin
        if (advance) begin
          if (walk_end) begin
            state_nxt = S_DONE;
          end else begin
            pos_nxt = pos_r + 1'b1;
          end
        end
      end
      S_DONE: begin
        state_nxt = S_LOAD;
      end
      default: state_nxt = S_LOAD;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state_r    <= S_LOAD;
      pos_r      <= '0;
      blk_r         <= '0;
      walk_last_r   <= PHASE_A;
      walk_biw_en_r <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      pos_r         <= pos_nxt;
      blk_r         <= blk_nxt;
      walk_last_r   <= walk_last_nxt;
      walk_biw_en_r <= walk_biw_en_nxt;
    end
  end

  // ------------------------------------------------------------
  // Output stage
  // ------------------------------------------------------------
  logic              ov_r, ov_nxt;
  logic [PKT_W-1:0]  od_r, od_nxt;

  assign fq.out_ready = !ov_r || pkt_ready_i;

  always_comb begin
    ov_nxt = ov_r;
    od_nxt = od_r;
    if (fq.out_ready) begin
      ov_nxt = fq.out_valid;
      if (fq.out_valid) begin
        od_nxt = fq.out_data;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ov_r <= 1'b0;
      od_r <= '0;
    end else begin
      ov_r <= ov_nxt;
      od_r <= od_nxt;
    end
  end

  assign pkt_valid_o = ov_r;
  assign {pkt_type_o, pkt_phase_o, pkt_block_o, pkt_ref_o, pkt_aux_o, pkt_data_o} = od_r;

endmodule

/* seq_props.sv */
module seq_props
  import pkt_seq_pkg::*;
(
  input wire logic                           mclk_i,
  input wire logic                           reset_i,
  input wire logic [1:0]                     rate_i,
  input wire logic                           biw_report_en_i,
  input wire logic                           blk_valid_i,
  input wire logic                           blk_ready_o,
  input wire logic [pkt_seq_pkg::PHASE_W-1:0] word_phase_i,
  input wire logic [pkt_seq_pkg::WNUM_W-1:0]  word_index_i,
  input wire logic                           pkt_valid_o,
  input wire logic                           pkt_ready_i,
  input wire logic [1:0]                     pkt_type_o,
  input wire logic [pkt_seq_pkg::PHASE_W-1:0] pkt_phase_o,
  input wire logic [pkt_seq_pkg::BLOCK_W-1:0] pkt_block_o,
  input wire logic [pkt_seq_pkg::WORD_W-1:0]  pkt_data_o
);
  logic [BLOCK_W-1:0] prev_blk_r;
  logic [PHASE_W-1:0] prev_ph_r;
  logic               seen_r;
  logic [PHASE_W-1:0] last_ph;

  // Last phase of a block for the current rate
  assign last_ph = (rate_i == RATE_HIGH) ? PHASE_D : rate_i;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      seen_r <= 1'b0;
    end else if (pkt_valid_o && pkt_ready_i) begin
      seen_r     <= 1'b1;
      prev_blk_r <= pkt_block_o;
      prev_ph_r  <= pkt_phase_o;
    end
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  AST_RESET: assert property (@(posedge mclk_i) disable iff (1'b0)
    reset_i |=> !pkt_valid_o && blk_ready_o) else $error("outputs wrong after reset");
  AST_VALID_HOLD: assert property (pkt_valid_o && !pkt_ready_i |=> pkt_valid_o)
    else $error("packet withdrawn while stalled");
  AST_DATA_HOLD: assert property (pkt_valid_o && !pkt_ready_i |=>
    $stable(pkt_data_o) && $stable(pkt_type_o)) else $error("packet changed while stalled");
  AST_RATE_LOW: assert property (pkt_valid_o && rate_i == RATE_LOW |->
    pkt_phase_o == PHASE_A) else $error("phase beyond A at low rate");
  AST_RATE_MID: assert property (pkt_valid_o && rate_i == RATE_MID |->
    pkt_phase_o <= PHASE_B) else $error("phase beyond B at mid rate");
  AST_BIW_OFF: assert property (pkt_valid_o && !biw_report_en_i |->
    pkt_type_o != PK_BIW) else $error("block info packet while reporting off");
  AST_LOAD_END: assert property (blk_valid_i && blk_ready_o && word_phase_i == last_ph &&
    word_index_i == WORDS_PER_BLOCK |=> !blk_ready_o [*8]) else $error("loading not closed");
  AST_PHASE_ORDER: assert property (pkt_valid_o && pkt_ready_i && seen_r &&
    pkt_block_o == prev_blk_r |-> pkt_phase_o >= prev_ph_r) else $error("phase order broken");
endmodule

bind pkt_sequencer seq_props seq_props_i (
  .mclk_i, .reset_i, .rate_i, .biw_report_en_i, .blk_valid_i, .blk_ready_o, .word_phase_i,
  .word_index_i, .pkt_valid_o, .pkt_ready_i, .pkt_type_o, .pkt_phase_o, .pkt_block_o,
  .pkt_data_o
);

/* host_sink.sv */
module host_sink
  import pkt_seq_pkg::*;
(
  input  wire logic                         mclk_i,
  input  wire logic                         reset_i,
  input  wire logic                         stall_i,
  input  wire logic                         pkt_valid_i,
  output logic                              pkt_ready_o,
  input  wire logic [pkt_seq_pkg::PKT_W-1:0] pkt_i
);
  logic [PKT_W-1:0] got[$];
  logic [1:0]       cnt_r;

  // With stall_i the host accepts one cycle in four, else every cycle
  assign pkt_ready_o = !reset_i && (!stall_i || cnt_r == 2'h3);

  always @(posedge mclk_i) begin
    cnt_r <= reset_i ? 2'h0 : cnt_r + 2'h1;
    if (!reset_i && pkt_valid_i && pkt_ready_o) begin
      got.push_back(pkt_i);
    end
  end
endmodule

/* testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pkt_seq_pkg::*;

  logic               mclk_i, reset_i, biw_report_en_i, blk_valid_i, blk_ready_o;
  logic [1:0]         rate_i, pkt_type_o;
  logic               pkt_valid_o, pkt_ready_i, stall;
  logic [BLOCK_W-1:0] blk_num_i, pkt_block_o;
  logic [PHASE_W-1:0] word_phase_i, pkt_phase_o;
  logic [2:0]         word_index_i, word_type_i;
  logic [7:0]         ref_index_i, ref_len_i, pkt_ref_o, pkt_aux_o;
  logic [WORD_W-1:0]  word_data_i, pkt_data_o;
  logic [PKT_W-1:0]   sl[32], exp_q[$];
  logic               sv[32];
  int                 n_errors, checks;

  pkt_sequencer pkt_sequencer_i (.*);
  host_sink host_sink_i (.mclk_i, .reset_i, .stall_i(stall), .pkt_valid_i(pkt_valid_o),
    .pkt_ready_o(pkt_ready_i),
    .pkt_i({pkt_type_o, pkt_phase_o, pkt_block_o, pkt_ref_o, pkt_aux_o, pkt_data_o}));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic fail();
    n_errors++;
    end_sim();
  endtask

  task automatic chk(input string nm, input logic [PKT_W-1:0] e, input logic [PKT_W-1:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Offer one word and note the packet it should give
  task automatic put(input logic [1:0] p, input logic [2:0] i, input logic [2:0] t,
                     input logic [7:0] r, input logic [7:0] l);
    logic [1:0] k;
    int         n;
    k = (t == 3'h4) ? 2'h1 : (t == 3'h5) ? 2'h2 : (t == 3'h1) ? 2'h3 : 2'h0;
    sv[{p, i}] = t != 3'h0 && i != 3'h0 && !(t == 3'h1 && !biw_report_en_i);
    sl[{p, i}] = {k, p, blk_num_i, r, l, 24'h5a5a5a, 1'b0, p, i, 2'h0};
    {blk_valid_i, word_phase_i, word_index_i, word_type_i, ref_index_i, ref_len_i} <=
      {1'b1, p, i, t, r, l};
    word_data_i <= {24'h5a5a5a, 1'b0, p, i, 2'h0};
    n = 0;
    @(posedge mclk_i);
    while (blk_ready_o !== 1'b1) begin
      n++;
      if (n > 500) fail();
      @(posedge mclk_i);
    end
  endtask

  // Expected stream: phase ascending, then index ascending
  task automatic flush(input logic [1:0] last);
    int n;
    blk_valid_i <= 1'b0;
    for (int p = 0; p <= last; p++)
      for (int i = 0; i < 8; i++)
        if (sv[p*8+i]) exp_q.push_back(sl[p*8+i]);
    n = 0;
    while (host_sink_i.got.size() < exp_q.size()) begin
      n++;
      if (n > 3000) fail();
      @(posedge mclk_i);
    end
    repeat (10) @(posedge mclk_i);
    chk("count", PKT_W'(exp_q.size()), PKT_W'(host_sink_i.got.size()));
    foreach (exp_q[j]) chk("packet", exp_q[j], host_sink_i.got[j]);
    exp_q.delete();
    host_sink_i.got.delete();
    sv = '{default: 1'b0};
    blk_num_i <= blk_num_i + 4'h1;
  endtask

  task automatic test_mixed();
    rate_i <= RATE_MID;
    biw_report_en_i <= 1'b1;
    @(posedge mclk_i);
    put(2'h1, 3'h1, 3'h1, 8'h0, 8'h0);
    put(2'h1, 3'h2, 3'h3, 8'h4, 8'h0);
    put(2'h0, 3'h0, 3'h1, 8'h0, 8'h0);
    put(2'h0, 3'h2, 3'h2, 8'h5, 8'h0);
    put(2'h0, 3'h5, 3'h4, 8'h6, 8'h7);
    put(2'h0, 3'h6, 3'h5, 8'h6, 8'h0);
    put(2'h0, 3'h7, 3'h5, 8'h7, 8'h0);
    put(2'h1, 3'h4, 3'h4, 8'h5, 8'h7);
    put(2'h1, 3'h5, 3'h5, 8'h5, 8'h0);
    put(2'h1, 3'h0, 3'h1, 8'h0, 8'h0);
    put(2'h1, 3'h7, 3'h5, 8'h7, 8'h0);
    flush(2'h1);
    $display("test_mixed done");
  endtask

  task automatic test_rates();
    logic [1:0] last;
    for (int r = 0; r < 3; r++) begin
      last = (r == 2) ? 2'h3 : 2'(r);
      rate_i <= 2'(r);
      biw_report_en_i <= 1'b0;
      stall <= (r == 2);
      @(posedge mclk_i);
      for (int p = 0; p <= last; p++)
        for (int i = 0; i < 8; i++)
          put(2'(p), 3'(i), (i < 2) ? 3'h1 : 3'h5, 8'(i), 8'h0);
      flush(last);
    end
    $display("test_rates done");
  endtask

  initial begin
    {rate_i, biw_report_en_i, blk_valid_i, blk_num_i, stall} = '0;
    {word_phase_i, word_index_i, word_type_i, ref_index_i, ref_len_i, word_data_i} = '0;
    sv = '{default: 1'b0};
    n_errors = 0;
    checks = 0;
    reset_i = 1'b1;
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'b0;
    test_mixed();
    test_rates();
    end_sim();
  end
endmodule
